// *** cbsse_pkg.sv ***
// Shared constants and types of the branch, stack and shift execution unit.
// Assumes a single 40 MHz clock and an APB master with 32-bit data.
package cbsse_pkg;
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_SRC = 8'h04;
   localparam logic [7:0] ADDR_DST = 8'h08;
   localparam logic [7:0] ADDR_PC = 8'h0C;
   localparam logic [7:0] ADDR_SP = 8'h10;
   localparam logic [7:0] ADDR_SR = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam int INSTR_OP_LSB = 0;
   localparam int INSTR_BYTE = 4;
   localparam int INSTR_OFS_LSB = 16;
   localparam int STATUS_BUSY = 0;
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_GIE = 3;
   localparam int SR_CORE_HALT_BIT = 4;
   localparam int SR_OSCILLATOR_STOP_BIT = 5;
   localparam int SR_V = 8;
   localparam int SR_PCHI_LSB = 12;
   localparam logic [3:0] OP_BRANCH_NZ = 4'h0;
   localparam logic [3:0] OP_BRANCH_NE = 4'h1;
   localparam logic [3:0] OP_COPY = 4'h2;
   localparam logic [3:0] OP_IDLE = 4'h3;
   localparam logic [3:0] OP_STACK_LOAD = 4'h4;
   localparam logic [3:0] OP_STACK_STORE = 4'h5;
   localparam logic [3:0] OP_SUB_EXIT = 4'h6;
   localparam logic [3:0] OP_INT_EXIT = 4'h7;
   localparam logic [3:0] OP_SHIFT = 4'h8;
   localparam logic [19:0] PC_RESET = 20'h00000;
   localparam logic [19:0] SP_RESET = 20'h00400;
   localparam logic [15:0] SR_RESET = 16'h0000;
   localparam logic [19:0] STACK_STEP = 20'h00002;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_EXEC = 5'h02,
      ST_READ = 5'h04,
      ST_READ2 = 5'h08,
      ST_WRITE = 5'h10
   } cbsse_state_t;
   typedef struct packed {
      cbsse_state_t state;
      logic [3:0] op;
      logic byteMode;
      logic [9:0] offset;
      logic [19:0] pc;
      logic [19:0] sp;
      logic [15:0] sr;
      logic [15:0] src;
      logic [15:0] dst;
      logic memReq;
      logic memWe;
      logic [1:0] memBe;
      logic [19:0] memAddr;
      logic [15:0] memWdata;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cbsse_core_t;
endpackage

// *** cbsse_branch.sv ***
// Relative branch target of the conditional jump.
// Assumes the program counter already points past the jump instruction.
`timescale 1ns/1ps
module cbsse_branch (
   input wire logic [19:0] pc,
   input wire logic [9:0] offset,
   output logic [19:0] target
);
   // The word offset is doubled and sign extended to the full 20 bits.
   assign target = pc + {{9{offset[9]}}, offset, 1'b0};
endmodule

// *** cbsse_shift.sv ***
// Arithmetic left shift of a word or a byte with its status flags.
// Assumes the byte form works on the low byte and clears the high byte.
`timescale 1ns/1ps
module cbsse_shift (
   input wire logic [15:0] operand,
   input wire logic byteMode,
   output logic [15:0] result,
   output logic flagN,
   output logic flagZ,
   output logic flagC,
   output logic flagV
);
   always_comb
   begin
      if (byteMode)
      begin
         result = {8'h00, operand[6:0], 1'b0};
         flagC = operand[7];
         flagN = operand[6];
         flagV = (operand[7:0] >= 8'h40) && (operand[7:0] < 8'hC0);
      end
      else
      begin
         result = {operand[14:0], 1'b0};
         flagC = operand[15];
         flagN = operand[14];
         // The range test equals a sign change of the doubled value.
         flagV = (operand >= 16'h4000) && (operand < 16'hC000);
      end
      flagZ = (result == 16'h0000);
   end
endmodule

// *** cbsse_core.sv ***
// Execution unit for branch, copy, stack, return and left shift operations.
// Assumes an APB master and a stack memory that acks each request once.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cbsse_core (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic memReq,
   output logic memWe,
   output logic [1:0] memBe,
   output logic [19:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic [15:0] memRdata,
   input wire logic memAck
);
   import cbsse_pkg::*;

   cbsse_core_t core_r;
   cbsse_core_t core_nxt;
   logic [19:0] branchTarget;
   logic [15:0] shiftResult;
   logic shiftN;
   logic shiftZ;
   logic shiftC;
   logic shiftV;
   logic apbTake;
   logic apbDone;
   logic idle;

   cbsse_branch uBranch (
      .pc(core_r.pc),
      .offset(core_r.offset),
      .target(branchTarget)
   );

   cbsse_shift uShift (
      .operand(core_r.dst),
      .byteMode(core_r.byteMode),
      .result(shiftResult),
      .flagN(shiftN),
      .flagZ(shiftZ),
      .flagC(shiftC),
      .flagV(shiftV)
   );

   assign idle = (core_r.state == ST_IDLE);
   // Reads are answered in the second access cycle so data comes from a flop.
   assign apbTake = psel && penable && !core_r.pready;
   assign apbDone = psel && penable && core_r.pready;

   always_comb
   begin
      core_nxt = core_r;
      core_nxt.pready = 1'b0;
      core_nxt.pslverr = 1'b0;
      if (apbTake)
      begin
         core_nxt.pready = 1'b1;
         core_nxt.prdata = 32'h00000000;
         case (paddr)
            ADDR_INSTR:
            begin
               core_nxt.prdata[INSTR_OP_LSB +: 4] = core_r.op;
               core_nxt.prdata[INSTR_BYTE] = core_r.byteMode;
               core_nxt.prdata[INSTR_OFS_LSB +: 10] = core_r.offset;
            end
            ADDR_SRC: core_nxt.prdata[15:0] = core_r.src;
            ADDR_DST: core_nxt.prdata[15:0] = core_r.dst;
            ADDR_PC: core_nxt.prdata[19:0] = core_r.pc;
            ADDR_SP: core_nxt.prdata[19:0] = core_r.sp;
            ADDR_SR: core_nxt.prdata[15:0] = core_r.sr;
            ADDR_STATUS: core_nxt.prdata[STATUS_BUSY] = !idle;
            default: core_nxt.pslverr = 1'b1;
         endcase
      end
      // Architectural state is frozen for software while an operation runs.
      if (apbDone && pwrite && idle)
      begin
         case (paddr)
            ADDR_INSTR:
            begin
               core_nxt.op = pwdata[INSTR_OP_LSB +: 4];
               core_nxt.byteMode = pwdata[INSTR_BYTE];
               core_nxt.offset = pwdata[INSTR_OFS_LSB +: 10];
               core_nxt.state = ST_EXEC;
            end
            ADDR_SRC: core_nxt.src = pwdata[15:0];
            ADDR_DST: core_nxt.dst = pwdata[15:0];
            ADDR_PC: core_nxt.pc = pwdata[19:0];
            ADDR_SP: core_nxt.sp = pwdata[19:0];
            ADDR_SR: core_nxt.sr = pwdata[15:0];
            default: core_nxt.state = core_r.state;
         endcase
      end
      case (core_r.state)
         ST_IDLE:
         begin
            core_nxt.memReq = 1'b0;
            core_nxt.memWe = 1'b0;
         end
         ST_EXEC:
         begin
            core_nxt.state = ST_IDLE;
            case (core_r.op)
               OP_BRANCH_NZ, OP_BRANCH_NE:
               begin
                  // A set zero flag falls through with nothing changed.
                  if (!core_r.sr[SR_Z])
                  begin
                     core_nxt.pc = branchTarget;
                  end
               end
               OP_COPY:
               begin
                  if (core_r.byteMode)
                  begin
                     core_nxt.dst = {8'h00, core_r.src[7:0]};
                  end
                  else
                  begin
                     core_nxt.dst = core_r.src;
                  end
               end
               // A copy of zero into the constant register changes nothing.
               OP_IDLE: core_nxt.state = ST_IDLE;
               OP_STACK_LOAD, OP_SUB_EXIT, OP_INT_EXIT:
               begin
                  core_nxt.memReq = 1'b1;
                  core_nxt.memWe = 1'b0;
                  core_nxt.memBe = 2'b11;
                  core_nxt.memAddr = core_r.sp;
                  core_nxt.state = ST_READ;
               end
               OP_STACK_STORE:
               begin
                  core_nxt.sp = core_r.sp - STACK_STEP;
                  core_nxt.memAddr = core_r.sp - STACK_STEP;
                  core_nxt.memWdata = core_r.src;
                  core_nxt.memReq = 1'b1;
                  core_nxt.memWe = 1'b1;
                  // In byte mode only the low lane is enabled so the high byte survives.
                  core_nxt.memBe = core_r.byteMode ? 2'b01 : 2'b11;
                  core_nxt.state = ST_WRITE;
               end
               OP_SHIFT:
               begin
                  core_nxt.dst = shiftResult;
                  core_nxt.sr[SR_N] = shiftN;
                  core_nxt.sr[SR_Z] = shiftZ;
                  core_nxt.sr[SR_C] = shiftC;
                  core_nxt.sr[SR_V] = shiftV;
               end
               default: core_nxt.state = ST_IDLE;
            endcase
         end
         ST_READ:
         begin
            if (memAck)
            begin
               core_nxt.memReq = 1'b0;
               // The pointer moves by two even for a byte pop.
               core_nxt.sp = core_r.sp + STACK_STEP;
               core_nxt.state = ST_IDLE;
               case (core_r.op)
                  OP_STACK_LOAD:
                  begin
                     if (core_r.byteMode)
                     begin
                        core_nxt.dst = {8'h00, memRdata[7:0]};
                     end
                     else
                     begin
                        core_nxt.dst = memRdata;
                     end
                  end
                  OP_SUB_EXIT: core_nxt.pc = {4'h0, memRdata};
                  OP_INT_EXIT:
                  begin
                     // Mode bits come back only on this path.
                     core_nxt.sr = {4'h0, memRdata[SR_PCHI_LSB-1:0]};
                     core_nxt.pc[19:16] = memRdata[15:SR_PCHI_LSB];
                     core_nxt.memReq = 1'b1;
                     core_nxt.memAddr = core_r.sp + STACK_STEP;
                     core_nxt.state = ST_READ2;
                  end
                  default: core_nxt.state = ST_IDLE;
               endcase
            end
         end
         ST_READ2:
         begin
            if (memAck)
            begin
               core_nxt.memReq = 1'b0;
               core_nxt.pc[15:0] = memRdata;
               core_nxt.sp = core_r.sp + STACK_STEP;
               core_nxt.state = ST_IDLE;
            end
         end
         ST_WRITE:
         begin
            if (memAck)
            begin
               core_nxt.memReq = 1'b0;
               core_nxt.memWe = 1'b0;
               core_nxt.state = ST_IDLE;
            end
         end
         default: core_nxt.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         core_r <= '0;
         core_r.state <= ST_IDLE;
         core_r.pc <= PC_RESET;
         core_r.sp <= SP_RESET;
         core_r.sr <= SR_RESET;
      end
      else
      begin
         core_r <= core_nxt;
      end
   end

   assign prdata = core_r.prdata;
   assign pready = core_r.pready;
   assign pslverr = core_r.pslverr;
   assign memReq = core_r.memReq;
   assign memWe = core_r.memWe;
   assign memBe = core_r.memBe;
   assign memAddr = core_r.memAddr;
   assign memWdata = core_r.memWdata;

   AST_BRANCH_TAKEN: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && !core_r.sr[SR_Z]
         && (core_r.op == OP_BRANCH_NZ || core_r.op == OP_BRANCH_NE))
      |=> core_r.pc == $past(core_r.pc)
         + {{9{$past(core_r.offset[9])}}, $past(core_r.offset), 1'b0})
      else $error("Branch target wrong.");

   AST_BRANCH_FALL: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.sr[SR_Z]
         && core_r.op == OP_BRANCH_NZ)
      |=> $stable(core_r.pc) && $stable(core_r.sr) && idle)
      else $error("Branch with zero set changed state.");

   AST_COPY: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_COPY)
      |=> $stable(core_r.sr) && $stable(core_r.src)
         && core_r.dst[7:0] == $past(core_r.src[7:0]))
      else $error("Copy result or flags wrong.");

   AST_IDLE_OP: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_IDLE)
      |=> $stable(core_r.pc) && $stable(core_r.sp) && $stable(core_r.sr)
         && $stable(core_r.dst) && !memReq)
      else $error("Idle operation had an effect.");

   AST_POP: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_STACK_LOAD)
      |=> memReq && !memWe && memAddr == $past(core_r.sp)
         && memBe == 2'b11 && $stable(core_r.sp))
      else $error("Stack load pointer wrong.");

   AST_POP_BYTE: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_READ && memAck && core_r.op == OP_STACK_LOAD)
      |=> core_r.dst == (core_r.byteMode ? {8'h00, $past(memRdata[7:0])}
         : $past(memRdata)) && core_r.sp == $past(core_r.sp) + STACK_STEP)
      else $error("Stack load result wrong.");

   AST_PUSH: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_STACK_STORE)
      |=> memReq && memWe && memAddr == $past(core_r.sp) - STACK_STEP
         && core_r.sp == memAddr && memWdata == core_r.src
         && $stable(core_r.sr))
      else $error("Stack store address wrong.");

   AST_PUSH_BYTE: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (memReq && memWe) |-> memBe == (core_r.byteMode ? 2'b01 : 2'b11))
      else $error("Byte store lanes wrong.");

   AST_SUB_EXIT: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_READ && memAck && core_r.op == OP_SUB_EXIT)
      |=> core_r.pc == {4'h0, $past(memRdata)}
         && core_r.sp == $past(core_r.sp) + STACK_STEP && $stable(core_r.sr))
      else $error("Subroutine exit wrong.");

   AST_INT_EXIT: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_READ && memAck && core_r.op == OP_INT_EXIT)
      |=> core_r.state == ST_READ2 && memReq && memAddr == core_r.sp
         && core_r.pc[19:16] == $past(memRdata[15:12]))
      else $error("Interrupt exit first pop wrong.");

   AST_INT_FLAGS: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_READ && memAck && core_r.op == OP_INT_EXIT)
      |=> core_r.sr[SR_OSCILLATOR_STOP_BIT:0] == $past(memRdata[SR_OSCILLATOR_STOP_BIT:0])
         && core_r.sr[SR_V] == $past(memRdata[SR_V]))
      else $error("Interrupt exit flags wrong.");

   AST_MODE_KEEP: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (!idle && core_r.op != OP_INT_EXIT)
      |=> $stable(core_r.sr[SR_OSCILLATOR_STOP_BIT:SR_GIE]))
      else $error("Mode bits changed.");

   AST_SHIFT_WORD: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_SHIFT && !core_r.byteMode)
      |=> core_r.dst == $past(core_r.dst) + $past(core_r.dst)
         && core_r.sr[SR_C] == $past(core_r.dst[15]))
      else $error("Word shift wrong.");

   AST_SHIFT_OVF: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_SHIFT && !core_r.byteMode)
      |=> core_r.sr[SR_V] == ($past(core_r.dst[15]) ^ $past(core_r.dst[14])))
      else $error("Word shift overflow wrong.");

   AST_SHIFT_OVF_BYTE: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_SHIFT && core_r.byteMode)
      |=> core_r.sr[SR_V] == ($past(core_r.dst[7]) ^ $past(core_r.dst[6])))
      else $error("Byte shift overflow wrong.");

   AST_SHIFT_NZ: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (core_r.state == ST_EXEC && core_r.op == OP_SHIFT)
      |=> core_r.sr[SR_Z] == (core_r.dst == 16'h0000)
         && core_r.sr[SR_N] == (core_r.byteMode ? core_r.dst[7]
            : core_r.dst[15]))
      else $error("Shift negative or zero flag wrong.");
endmodule

// *** cbsse_mem.sv ***
// Behavioural stack memory on the far side of the execution unit.
// Assumes one request at a time, held by the core until it is acked.
`timescale 1ns/1ps
module cbsse_mem (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [1:0] memBe,
   input wire logic [19:0] memAddr,
   input wire logic [15:0] memWdata,
   output logic [15:0] memRdata,
   output logic memAck
);
   logic [15:0] mem [0:1023];
   logic [1:0] waitCnt;
   logic [1:0] step;
   logic [9:0] idx;
   assign idx = memAddr[10:1];
   initial
   begin
      memAck = 1'b0;
      memRdata = 16'h0000;
      waitCnt = 2'h0;
      step = 2'h0;
   end
   // Outside a read ack the read bus toggles, so stale data is never trusted.
   always @(posedge mclk)
   begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (!rst_n)
         waitCnt <= 2'h0;
      else if (memReq && !memAck)
      begin
         if (waitCnt == 2'h0)
         begin
            memAck <= 1'b1;
            if (memWe)
            begin
               if (memBe[0])
                  mem[idx][7:0] <= memWdata[7:0];
               if (memBe[1])
                  mem[idx][15:8] <= memWdata[15:8];
            end
            else
               memRdata <= mem[idx];
            step <= step + 2'h1;
            waitCnt <= slow ? step : 2'h0;
         end
         else
            waitCnt <= waitCnt - 2'h1;
      end
   end
endmodule

// *** cbsse_core_test.sv ***
// Self-checking bench of the execution unit, driven over APB.
// Assumes the stack memory model answers with varying latency.
`timescale 1ns/1ps
`define CHK(nm, e, s) \
   begin \
      num_checks++; \
      if ((e) !== (s)) \
      begin \
         num_errors++; \
         $display("BAD %s expected %h seen %h", nm, e, s); \
      end \
   end
module cbsse_core_test;
   import cbsse_pkg::*;
   typedef struct {logic [31:0] exp; bit chk; string nm;
      logic err;} cbsse_note_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, memReq, memWe, memAck;
   logic [1:0] memBe;
   logic [19:0] memAddr;
   logic [15:0] memWdata, memRdata;
   logic slow = 1'b0;
   int seed = 89;
   int num_errors = 0;
   int num_checks = 0;
   logic [31:0] lastRd;
   cbsse_note_t notes[$];
   cbsse_note_t cur;
   always #12.5 mclk = ~mclk;
   cbsse_core cbsse_core_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
      .memWe(memWe), .memBe(memBe), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck));
   cbsse_mem cbsse_mem_i (.mclk(mclk), .rst_n(rst_n), .slow(slow),
      .memReq(memReq), .memWe(memWe), .memBe(memBe), .memAddr(memAddr),
      .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
   // Oldest note is matched against each completed read.
   always @(posedge mclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
      begin
         cur = notes.pop_front();
         if (cur.chk)
            `CHK(cur.nm, cur.exp, prdata)
         `CHK("pslverr", cur.err, pslverr)
      end
   end
   task results();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         n++;
      end
      lastRd = prdata;
      if (n >= 50)
      begin
         num_errors++;
         results();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      notes.push_back('{e, 1'b1, nm, a > ADDR_STATUS});
      apb(1'b0, a, 32'h0);
   endtask
   // Busy polling keeps to the ordering the core asks of software.
   task run(input logic [3:0] op, input logic b, input logic [9:0] ofs);
      int n;
      wr(ADDR_INSTR, {6'h00, ofs, 11'h000, b, op});
      n = 0;
      do
      begin
         notes.push_back('{32'h0, 1'b0, "busy", 1'b0});
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end
      while (lastRd[STATUS_BUSY] !== 1'b0 && n < 40);
      if (n >= 40)
      begin
         num_errors++;
         results();
      end
   endtask
   task push(input logic [19:0] sp, input logic [15:0] v, input logic b);
      wr(ADDR_SP, {12'h000, sp});
      wr(ADDR_SRC, {16'h0000, v});
      run(OP_STACK_STORE, b, 10'h000);
   endtask
   initial
   begin
      #(25 * 40000);
      num_errors++;
      results();
   end
   initial
   begin
      logic [9:0] ofsT [3];
      logic [15:0] tab [5];
      logic [15:0] srT [2];
      logic [15:0] v, r, se;
      logic [19:0] pe;
      ofsT = '{10'h1FF, 10'h200, 10'h001};
      tab = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'h8000};
      srT = '{16'h5127, 16'h0002};
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ADDR_PC, 32'h0, "pc");
      rd(ADDR_SP, 32'h400, "sp");
      rd(ADDR_SR, 32'h0, "sr");
      rd(8'h1C, 32'h0, "unmapped");
      $display("test reset done");
      for (int z = 0; z < 2; z++)
         for (int op = 0; op < 2; op++)
            for (int i = 0; i < 3; i++)
            begin
               wr(ADDR_PC, 32'h100);
               wr(ADDR_SR, z ? 32'h3A : 32'h38);
               run(op[3:0], 1'b0, ofsT[i]);
               pe = 20'h00100 + {{9{ofsT[i][9]}}, ofsT[i], 1'b0};
               if (z)
                  pe = 20'h00100;
               rd(ADDR_PC, {12'h000, pe}, "pc");
               rd(ADDR_SR, z ? 32'h3A : 32'h38, "sr");
            end
      $display("test branch done");
      for (int b = 0; b < 2; b++)
      begin
         v = $random(seed);
         wr(ADDR_SRC, {16'h0000, v});
         wr(ADDR_DST, 32'hFFFF);
         wr(ADDR_SR, 32'h13F);
         run(OP_COPY, b[0], 10'h000);
         rd(ADDR_DST, b ? {24'h0, v[7:0]} : {16'h0, v}, "dst");
         rd(ADDR_SRC, {16'h0, v}, "src");
         rd(ADDR_SR, 32'h13F, "sr");
      end
      // An undefined opcode must leave every register as it was.
      run(4'hF, 1'b1, 10'h3FF);
      run(OP_IDLE, 1'b0, 10'h000);
      rd(ADDR_DST, {24'h0, v[7:0]}, "dst");
      rd(ADDR_SR, 32'h13F, "sr");
      rd(ADDR_SP, 32'h400, "sp");
      rd(ADDR_PC, 32'h100, "pc");
      $display("test copy done");
      push(20'h00400, 16'hA5C3, 1'b0);
      rd(ADDR_SP, 32'h3FE, "sp");
      push(20'h00400, 16'h1177, 1'b1);
      run(OP_STACK_LOAD, 1'b0, 10'h000);
      rd(ADDR_DST, 32'hA577, "dst");
      rd(ADDR_SP, 32'h400, "sp");
      wr(ADDR_SP, 32'h3FE);
      run(OP_STACK_LOAD, 1'b1, 10'h000);
      rd(ADDR_DST, 32'h77, "dst");
      rd(ADDR_SP, 32'h400, "sp");
      rd(ADDR_SR, 32'h13F, "sr");
      push(20'h00000, 16'h0001, 1'b0);
      rd(ADDR_SP, 32'hFFFFE, "sp");
      $display("test stack done");
      slow <= 1'b1;
      push(20'h00400, 16'h1234, 1'b0);
      wr(ADDR_PC, 32'hF0000);
      run(OP_SUB_EXIT, 1'b0, 10'h000);
      rd(ADDR_PC, 32'h01234, "pc");
      rd(ADDR_SP, 32'h400, "sp");
      rd(ADDR_SR, 32'h13F, "sr");
      for (int i = 0; i < 2; i++)
      begin
         push(20'h00400, 16'hBEEF, 1'b0);
         push(20'h003FE, srT[i], 1'b0);
         wr(ADDR_SR, i ? 32'h38 : 32'h0);
         run(OP_INT_EXIT, 1'b0, 10'h000);
         rd(ADDR_SR, {20'h0, srT[i][11:0]}, "sr");
         rd(ADDR_PC, {12'h0, srT[i][15:12], 16'hBEEF}, "pc");
         rd(ADDR_SP, 32'h400, "sp");
      end
      $display("test return done");
      for (int b = 0; b < 2; b++)
         for (int i = 0; i < 8; i++)
         begin
            v = $random(seed);
            if (i < 5)
               v = b ? {v[15:8], tab[i][15:8]} : tab[i];
            se = 16'h0038;
            if (b)
            begin
               r = {8'h00, v[6:0], 1'b0};
               se[SR_C] = v[7];
               se[SR_V] = v[7:0] >= 8'h40 && v[7:0] < 8'hC0;
               se[SR_N] = r[7];
               se[SR_Z] = r[7:0] == 8'h00;
            end
            else
            begin
               r = {v[14:0], 1'b0};
               se[SR_C] = v[15];
               se[SR_V] = v >= 16'h4000 && v < 16'hC000;
               se[SR_N] = r[15];
               se[SR_Z] = r == 16'h0000;
            end
            wr(ADDR_DST, {16'h0000, v});
            wr(ADDR_SR, 32'h38);
            run(OP_SHIFT, b[0], 10'h000);
            rd(ADDR_DST, {16'h0, r}, "dst");
            rd(ADDR_SR, {16'h0, se}, "sr");
         end
      $display("test shift done");
      results();
   end
endmodule
